//--- cntdn_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the countdown block
// Assumes: core clock of 10 MHz
// Notes:   times are in microseconds as printed; cycle counts derive from them
`ifndef CNTDN_CFG_SVH
`define CNTDN_CFG_SVH

`define CNTDN_CLK_MHZ         10
`define CNTDN_ADDR_CTRL2      8'h01
`define CNTDN_ADDR_VALUE      8'h10
`define CNTDN_ADDR_MODE       8'h11
`define CNTDN_CTRL2_MIN_BIT   5
`define CNTDN_CTRL2_HALF_BIT  4
`define CNTDN_CTRL2_FLAG_BIT  3
`define CNTDN_MODE_RST        5'h18
`define CNTDN_VALUE_RST       8'h00
`define CNTDN_CTRL2_RST       1'b0
`define CNTDN_PW_SHORT_US     122
`define CNTDN_PW_LONG_US      244
`define CNTDN_PW_64_ONE_US    7812
`define CNTDN_PW_STD_US       15625
`define CNTDN_PW_SHORT_CYC    (`CNTDN_PW_SHORT_US * `CNTDN_CLK_MHZ)
`define CNTDN_PW_LONG_CYC     (`CNTDN_PW_LONG_US * `CNTDN_CLK_MHZ)
`define CNTDN_PW_64_ONE_CYC   (`CNTDN_PW_64_ONE_US * `CNTDN_CLK_MHZ)
`define CNTDN_PW_STD_CYC      (`CNTDN_PW_STD_US * `CNTDN_CLK_MHZ)
`define CNTDN_DIV4096_MASK    9'h007
`define CNTDN_DIV64_MASK      9'h1FF
`define CNTDN_SEC_LAST        6'h3B
`define CNTDN_HALF_LAST       6'h1D

`endif

//--- cntdn_pkg.sv
// Purpose: shared types of the countdown and minute interrupt block
// Assumes: constants live in cntdn_cfg.svh
// Notes:   mode struct matches the low five bits of the timer mode register
package cntdn_pkg;

  typedef enum logic [1:0] {
    SRC_4096HZ,
    SRC_64HZ,
    SRC_1HZ,
    SRC_60S
  } cntdn_src_type;

  typedef struct packed {
    cntdn_src_type src;
    logic          run;
    logic          irq_en;
    logic          pulse_mode;
  } cntdn_mode_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cntdn_regreq_type;

  typedef struct packed {
    logic t4096;
    logic t64;
  } cntdn_ticks_type;

endpackage : cntdn_pkg

//--- cntdn_prescale.sv
// Purpose: derive 4.096 kHz and 64 Hz ticks from the 32.768 kHz oscillator pin
// Assumes: oscillator pin is asynchronous to core_clk_i
// Notes:   free running, so a freshly enabled countdown sees a random first phase
`include "cntdn_cfg.svh"
module cntdn_prescale (
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     ce_i,
  input  wire logic                     osc_32k_i,
  output cntdn_pkg::cntdn_ticks_type    ticks_o
);
  logic       osc_meta;
  logic       osc_sync;
  logic       osc_prev;
  logic [8:0] div_cnt;
  logic       osc_rise;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else if (ce_i) begin
      osc_meta <= osc_32k_i;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  assign osc_rise = osc_sync & ~osc_prev;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= 9'h000;
    end else if (ce_i && osc_rise) begin
      div_cnt <= div_cnt + 9'h001;
    end
  end

  assign ticks_o.t4096 = osc_rise && ((div_cnt & `CNTDN_DIV4096_MASK) == `CNTDN_DIV4096_MASK);
  assign ticks_o.t64   = osc_rise && (div_cnt == `CNTDN_DIV64_MASK);

endmodule : cntdn_prescale

//--- cntdn_pulse.sv
// Purpose: one-shot pulse of a programmable number of core cycles
// Assumes: width_i is at least one
// Notes:   active in the very cycle of the start so flag and pin rise together
module cntdn_pulse (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        start_i,
  input  wire logic [17:0] width_i,
  output logic             active_o
);
  logic [17:0] left_cnt;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_cnt <= 18'h00000;
    end else if (ce_i) begin
      if (start_i) begin
        left_cnt <= width_i - 18'h00001;
      end else if (left_cnt != 18'h00000) begin
        left_cnt <= left_cnt - 18'h00001;
      end
    end
  end

  assign active_o = start_i || (left_cnt != 18'h00000);

  a_pulse_load: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && start_i |=> left_cnt == $past(width_i) - 18'h00001)
    else $error("pulse width not loaded");

endmodule : cntdn_pulse

//--- cntdn_top.sv
// Purpose: countdown timer with timer flag and minute / half-minute interrupt generators
// Assumes: sec_tick_i and sec_value_i come from the calendar on core_clk_i
// Notes:   interrupt pin is open drain, active low; register port is a plain strobe port
`include "cntdn_cfg.svh"
module cntdn_top #(
  parameter logic [17:0] PW_64_ONE_CYC = 18'(`CNTDN_PW_64_ONE_CYC),
  parameter logic [17:0] PW_STD_CYC    = 18'(`CNTDN_PW_STD_CYC)
) (
  input  wire logic                        core_clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        ce_i,
  input  wire logic                        osc_32k_i,
  input  wire logic                        sec_tick_i,
  input  wire logic [5:0]                  sec_value_i,
  input  wire logic                        offset_fast_i,
  input  wire logic                        comp_add_i,
  input  wire logic                        comp_drop_i,
  input  wire cntdn_pkg::cntdn_regreq_type reg_req_i,
  output logic [7:0]                       reg_rdata_o,
  output logic                             irq_pin_o,
  output logic                             irq_oe_n_o
);
  localparam logic [17:0] PW_SHORT_CYC = 18'(`CNTDN_PW_SHORT_CYC);
  localparam logic [17:0] PW_LONG_CYC  = 18'(`CNTDN_PW_LONG_CYC);

  cntdn_pkg::cntdn_mode_type  mode;
  cntdn_pkg::cntdn_ticks_type ticks;
  logic [7:0]  countdown_reload;
  logic [7:0]  countdown_value;
  logic        timer_flag;
  logic        sixty_second_irq_en;
  logic        thirty_second_irq_en;
  logic        drop_pending;
  logic        irq_active;
  logic        src_tick;
  logic        tick_64;
  logic        expire;
  logic        minute_event;
  logic        half_event;
  logic        sec_event;
  logic        wr_value;
  logic        wr_mode;
  logic        wr_ctrl2;
  logic        flag_clear;
  logic        next_flag;
  logic        next_irq;
  logic        timer_pulse;
  logic        sec_pulse;
  logic [17:0] timer_width;

  function automatic logic hit(input cntdn_pkg::cntdn_regreq_type req, input logic [7:0] addr);
    hit = req.addr == addr;
  endfunction : hit

  function automatic logic [17:0] pulse_width(input cntdn_pkg::cntdn_src_type src, input logic [7:0] value);
    logic one;
    one = value == 8'h01;
    unique case (src)
      cntdn_pkg::SRC_4096HZ: pulse_width = one ? PW_SHORT_CYC : PW_LONG_CYC;
      cntdn_pkg::SRC_64HZ:   pulse_width = one ? PW_64_ONE_CYC : PW_STD_CYC;
      cntdn_pkg::SRC_1HZ:    pulse_width = PW_STD_CYC;
      cntdn_pkg::SRC_60S:    pulse_width = PW_STD_CYC;
    endcase
  endfunction : pulse_width

  assign wr_value = reg_req_i.wr && hit(reg_req_i, `CNTDN_ADDR_VALUE);
  assign wr_mode  = reg_req_i.wr && hit(reg_req_i, `CNTDN_ADDR_MODE);
  assign wr_ctrl2 = reg_req_i.wr && hit(reg_req_i, `CNTDN_ADDR_CTRL2);

  cntdn_prescale u_prescale (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .osc_32k_i  (osc_32k_i),
    .ticks_o    (ticks)
  );

  // 64 Hz sees compensation only in fast offset mode; 1 Hz arrives already compensated
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drop_pending <= 1'b0;
    end else if (ce_i) begin
      if (offset_fast_i && comp_drop_i) begin
        drop_pending <= 1'b1;
      end else if (ticks.t64) begin
        drop_pending <= 1'b0;
      end
    end
  end

  assign tick_64 = (ticks.t64 && !drop_pending) || (offset_fast_i && comp_add_i);

  assign sec_event    = sec_tick_i;
  assign minute_event = sec_tick_i && (sec_value_i == `CNTDN_SEC_LAST);
  assign half_event   = sec_tick_i && ((sec_value_i == `CNTDN_SEC_LAST) ||
                                       (sec_value_i == `CNTDN_HALF_LAST));

  always_comb begin
    unique case (mode.src)
      cntdn_pkg::SRC_4096HZ: src_tick = ticks.t4096;
      cntdn_pkg::SRC_64HZ:   src_tick = tick_64;
      cntdn_pkg::SRC_1HZ:    src_tick = sec_event;
      cntdn_pkg::SRC_60S:    src_tick = minute_event;
    endcase
  end

  // expiry only while running and loaded with a nonzero value
  assign expire = mode.run && src_tick && (countdown_value == 8'h01) && !wr_value;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      countdown_reload <= `CNTDN_VALUE_RST;
    end else if (ce_i && wr_value) begin
      countdown_reload <= reg_req_i.wdata;
    end
  end

  // a write lands in the live counter at once; the stored copy serves every later reload
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      countdown_value <= `CNTDN_VALUE_RST;
    end else if (ce_i) begin
      if (wr_value) begin
        countdown_value <= reg_req_i.wdata;
      end else if (expire) begin
        countdown_value <= countdown_reload;
      end else if (mode.run && src_tick && countdown_value != 8'h00) begin
        countdown_value <= countdown_value - 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode <= cntdn_pkg::cntdn_mode_type'(`CNTDN_MODE_RST);
    end else if (ce_i && wr_mode) begin
      mode <= cntdn_pkg::cntdn_mode_type'(reg_req_i.wdata[4:0]);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sixty_second_irq_en  <= `CNTDN_CTRL2_RST;
      thirty_second_irq_en <= `CNTDN_CTRL2_RST;
    end else if (ce_i && wr_ctrl2) begin
      sixty_second_irq_en  <= reg_req_i.wdata[`CNTDN_CTRL2_MIN_BIT];
      thirty_second_irq_en <= reg_req_i.wdata[`CNTDN_CTRL2_HALF_BIT];
    end
  end

  // writing zero to the flag bit clears it; a same-cycle event still wins
  assign flag_clear = wr_ctrl2 && !reg_req_i.wdata[`CNTDN_CTRL2_FLAG_BIT];

  logic timer_start;
  logic sec_start;
  assign timer_start = expire;
  assign sec_start   = (sixty_second_irq_en && minute_event) ||
                       (thirty_second_irq_en && half_event);

  assign next_flag = timer_start || sec_start || (timer_flag && !flag_clear);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_flag <= 1'b0;
    end else if (ce_i) begin
      timer_flag <= next_flag;
    end
  end

  assign timer_width = pulse_width(mode.src, countdown_reload);

  cntdn_pulse u_timer_pulse (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .start_i    (timer_start),
    .width_i    (timer_width),
    .active_o   (timer_pulse)
  );

  // the minute pulses assume normal offset mode; width is fixed either way
  cntdn_pulse u_sec_pulse (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .start_i    (sec_start),
    .width_i    (PW_STD_CYC),
    .active_o   (sec_pulse)
  );

  // interval mode holds the pin as long as the flag stands, so a second event
  // before the clear adds nothing; pulse mode never looks at the flag
  always_comb begin
    if (mode.pulse_mode) begin
      next_irq = (mode.irq_en && timer_pulse) || sec_pulse;
    end else begin
      next_irq = next_flag && (mode.irq_en || sixty_second_irq_en || thirty_second_irq_en);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_active <= 1'b0;
    end else if (ce_i) begin
      irq_active <= next_irq;
    end
  end

  assign irq_pin_o  = 1'b0;
  assign irq_oe_n_o = ~irq_active;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i && reg_req_i.rd) begin
      if (hit(reg_req_i, `CNTDN_ADDR_VALUE)) begin
        reg_rdata_o <= countdown_value;
      end else if (hit(reg_req_i, `CNTDN_ADDR_MODE)) begin
        reg_rdata_o <= {3'h0, mode};
      end else if (hit(reg_req_i, `CNTDN_ADDR_CTRL2)) begin
        reg_rdata_o <= 8'h00 | (8'(sixty_second_irq_en) << `CNTDN_CTRL2_MIN_BIT)
                             | (8'(thirty_second_irq_en) << `CNTDN_CTRL2_HALF_BIT)
                             | (8'(timer_flag) << `CNTDN_CTRL2_FLAG_BIT);
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  a_flag_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    timer_flag && !(ce_i && flag_clear) |=> timer_flag)
    else $error("timer flag dropped without a clear");

  a_flag_on_expiry: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && expire |=> timer_flag && countdown_value == $past(countdown_reload))
    else $error("expiry did not flag and reload");

  a_count_down: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && mode.run && src_tick && countdown_value > 8'h01 && !wr_value
    |=> countdown_value == $past(countdown_value) - 8'h01)
    else $error("counter did not decrement by one");

  a_stopped_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !mode.run && !wr_value
    |=> countdown_value == $past(countdown_value) && (!$rose(timer_flag) || $past(sec_start)))
    else $error("stopped timer moved");

  a_value_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && wr_value |=> countdown_value == $past(reg_req_i.wdata) && countdown_reload == $past(reg_req_i.wdata))
    else $error("value write not taken at once");

  a_live_read: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && reg_req_i.rd && hit(reg_req_i, `CNTDN_ADDR_VALUE) |=> reg_rdata_o == $past(countdown_value))
    else $error("read did not return live count");

  a_flag_pin_together: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && expire && mode.irq_en |=> timer_flag && !irq_oe_n_o)
    else $error("flag and pin not asserted together");

  a_interval_level: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $past(ce_i) && !$past(mode.pulse_mode)
    |-> irq_active == (timer_flag && $past(mode.irq_en || sixty_second_irq_en || thirty_second_irq_en)))
    else $error("interval pin does not follow flag");

  a_minute_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && sixty_second_irq_en && sec_tick_i && sec_value_i == `CNTDN_SEC_LAST |=> timer_flag)
    else $error("minute event did not set flag");

endmodule : cntdn_top

//--- cntdn_host.sv
// Purpose: host model that reaches the countdown registers over the strobe port
// Assumes: tasks are entered at a falling clock edge
// Notes:   each access holds its strobe across exactly one rising edge
`include "cntdn_cfg.svh"
module cntdn_host (
  input  wire logic                  core_clk_i,
  input  wire logic [7:0]            rdata_i,
  output cntdn_pkg::cntdn_regreq_type req_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial req_o = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req_o = '{1'b1, 1'b0, a, d};
    @(negedge core_clk_i);
    req_o.wr = 1'b0;
    @(negedge core_clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req_o = '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk_i);
    req_o.rd = 1'b0;
    @(negedge core_clk_i);
    d = rdata_i;
  endtask : rd

  // the live count moves under the read, so accept two equal reads
  task automatic rd_live(output logic [7:0] d);
    logic [7:0] a;
    rd(`CNTDN_ADDR_VALUE, a);
    repeat (3) begin
      rd(`CNTDN_ADDR_VALUE, d);
      if (d === a) break;
      a = d;
    end
  endtask : rd_live

  // stop the timer before the reload changes, then start it
  task automatic set_timer(input logic [7:0] mode, input logic [7:0] v);
    wr(`CNTDN_ADDR_MODE, mode & 8'hFB);
    wr(`CNTDN_ADDR_VALUE, v);
    wr(`CNTDN_ADDR_MODE, mode);
  endtask : set_timer
endmodule : cntdn_host

//--- tb.sv
// Purpose: self-checking bench of the countdown and minute interrupt block
// Assumes: oscillator pin sped up for the 64 Hz checks so the long counts stay short
// Notes:   64 Hz and standard pulse widths shortened by parameters
`include "cntdn_cfg.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int P64  = 20;
  localparam int PSTD = 40;
  logic                        core_clk_i = 1'b0;
  logic                        rst_n_i    = 1'b0;
  logic                        sec_tick   = 1'b0;
  logic [5:0]                  sec_value  = 6'h00;
  logic                        osc        = 1'b0;
  int                          osc_half   = 16000;
  logic [7:0]                  rdata;
  logic [7:0]                  got;
  logic [7:0]                  v;
  logic                        irq_pin;
  logic                        irq_oe_n;
  logic                        offset_fast = 1'b0;
  logic                        comp_add    = 1'b0;
  logic                        comp_drop   = 1'b0;
  cntdn_pkg::cntdn_regreq_type req;
  int                          miscompares     = 0;
  int                          samples_checked = 0;
  logic [31:0]                 seed            = 32'h8F88;
  int                          w;

  always #50 core_clk_i = ~core_clk_i;

  // start offset of 3700 puts every oscillator edge on a falling core clock edge
  initial begin
    #3700;
    forever begin
      #(osc_half) osc = ~osc;
    end
  end

  cntdn_top #(.PW_64_ONE_CYC(18'(P64)), .PW_STD_CYC(18'(PSTD))) dut (
    .core_clk_i   (core_clk_i),
    .rst_n_i      (rst_n_i),
    .ce_i         (1'b1),
    .osc_32k_i    (osc),
    .sec_tick_i   (sec_tick),
    .sec_value_i  (sec_value),
    .offset_fast_i(offset_fast),
    .comp_add_i   (comp_add),
    .comp_drop_i  (comp_drop),
    .reg_req_i    (req),
    .reg_rdata_o  (rdata),
    .irq_pin_o    (irq_pin),
    .irq_oe_n_o   (irq_oe_n)
  );

  cntdn_host host (
    .core_clk_i(core_clk_i),
    .rdata_i   (rdata),
    .req_o     (req)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic int exp_w(input logic [1:0] src, input logic [7:0] val);
    case (src)
      2'b00: return (val == 8'h01) ? `CNTDN_PW_SHORT_CYC : `CNTDN_PW_LONG_CYC;
      2'b01: return (val == 8'h01) ? P64 : PSTD;
      default: return PSTD;
    endcase
  endfunction : exp_w

  task automatic sec(input logic [5:0] s);
    sec_value = s;
    sec_tick  = 1'b1;
    @(negedge core_clk_i);
    sec_tick  = 1'b0;
  endtask : sec

  // one compensation pulse, add or drop, with the offset mode given
  task automatic comp_pulse(input logic fast, input logic drop);
    offset_fast = fast;
    comp_add    = !drop;
    comp_drop   = drop;
    @(negedge core_clk_i);
    comp_add    = 1'b0;
    comp_drop   = 1'b0;
    @(negedge core_clk_i);
  endtask : comp_pulse

  // waits up to wmax cycles for the pin, then counts low cycles up to maxw
  task automatic pulse(input int wmax, input int maxw, output int wd);
    int n;
    n  = 0;
    wd = 0;
    while (irq_oe_n !== 1'b0 && n < wmax) begin
      @(negedge core_clk_i);
      n++;
    end
    while (irq_oe_n === 1'b0 && wd < maxw) begin
      wd++;
      @(negedge core_clk_i);
    end
  endtask : pulse

  task automatic check_pulse(input logic [7:0] mode, input logic [7:0] val, input string n);
    host.set_timer(mode, val);
    pulse(20000, 5000, w);
    `CHK(n, exp_w(mode[4:3], val), w)
  endtask : check_pulse

  task automatic close_out();
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    #9000000;
    miscompares++;
    close_out();
  end

  initial begin
    repeat (2) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    @(negedge core_clk_i);
    host.rd(8'h10, got);
    `CHK("value rst", `CNTDN_VALUE_RST, got)
    host.rd(8'h11, got);
    `CHK("mode rst", `CNTDN_MODE_RST, got)
    host.rd(8'h01, got);
    `CHK("ctrl2 rst", 8'h00, got)
    host.rd(8'h05, got);
    `CHK("unmapped", 8'h00, got)
    `CHK("pin rst", 1'b1, irq_oe_n)
    `CHK("pin data", 1'b0, irq_pin)
    check_pulse(8'h07, 8'h01, "w4096 one");
    check_pulse(8'h07, 8'h02, "w4096 many");
    host.wr(8'h11, 8'h03);
    host.rd(8'h01, got);
    `CHK("flag set", 8'h08, got)
    host.wr(8'h01, 8'h00);
    host.rd(8'h01, got);
    `CHK("flag clr", 8'h00, got)
    osc_half = 400;
    check_pulse(8'h0F, 8'h01, "w64 one");
    check_pulse(8'h0F, 8'h02, "w64 many");
    // a 64 Hz tick has just passed, so the next one is a full period away
    host.set_timer(8'h0C, 8'h03);
    comp_pulse(1'b1, 1'b0);
    comp_pulse(1'b1, 1'b0);
    host.rd(8'h10, got);
    `CHK("fast add", 8'h01, got)
    comp_pulse(1'b0, 1'b0);
    host.rd(8'h10, got);
    `CHK("normal add", 8'h01, got)
    comp_pulse(1'b1, 1'b1);
    repeat (4200) @(negedge core_clk_i);
    host.rd(8'h10, got);
    `CHK("fast drop", 8'h01, got)
    offset_fast = 1'b0;
    osc_half = 16000;
    host.wr(8'h11, 8'h03);
    host.wr(8'h01, 8'h00);
    host.set_timer(8'h06, 8'h01);
    pulse(20000, 6000, w);
    `CHK("level held", 6000, w)
    host.wr(8'h11, 8'h02);
    host.wr(8'h01, 8'h00);
    `CHK("level clr", 1'b1, irq_oe_n)
    host.set_timer(8'h04, 8'h01);
    pulse(6000, 10, w);
    `CHK("irq masked", 0, w)
    host.wr(8'h11, 8'h03);
    host.rd(8'h01, got);
    `CHK("masked flag", 8'h08, got)
    host.wr(8'h01, 8'h00);
    host.wr(8'h10, 8'h03);
    repeat (8000) @(negedge core_clk_i);
    host.rd(8'h10, got);
    `CHK("stopped count", 8'h03, got)
    host.rd(8'h01, got);
    `CHK("stopped flag", 8'h00, got)
    host.set_timer(8'h07, 8'h00);
    pulse(6000, 10, w);
    `CHK("zero stops", 0, w)
    host.set_timer(8'h17, 8'h03);
    sec(6'h0A);
    @(negedge core_clk_i);
    sec(6'h0A);
    host.rd_live(got);
    `CHK("live count", 8'h01, got)
    sec(6'h0A);
    pulse(10, 100, w);
    `CHK("w1hz", exp_w(2'b10, 8'h03), w)
    host.rd(8'h10, got);
    `CHK("reload", 8'h03, got)
    host.set_timer(8'h1F, 8'h01);
    sec(6'h3A);
    pulse(10, 100, w);
    `CHK("no tick 58", 0, w)
    sec(6'h3B);
    pulse(10, 100, w);
    `CHK("w60", exp_w(2'b11, 8'h01), w)
    host.wr(8'h11, 8'h01);
    host.wr(8'h01, 8'h20);
    sec(6'h1D);
    pulse(10, 100, w);
    `CHK("min at 29", 0, w)
    sec(6'h3B);
    pulse(10, 100, w);
    `CHK("min at 59", PSTD, w)
    host.wr(8'h01, 8'h10);
    sec(6'h1D);
    pulse(10, 100, w);
    `CHK("half at 29", PSTD, w)
    host.rd(8'h01, got);
    `CHK("half flag", 8'h18, got)
    host.wr(8'h01, 8'h30);
    sec(6'h1D);
    pulse(10, 100, w);
    `CHK("both at 29", PSTD, w)
    host.wr(8'h01, 8'h00);
    host.wr(8'h11, 8'h03);
    for (int i = 0; i < 8; i++) begin
      v = 8'(rnd() % 255 + 1);
      host.wr(8'h10, v);
      host.rd(8'h10, got);
      `CHK("value rw", v, got)
    end
    close_out();
  end
endmodule : tb
